// ---- cer_pkg.sv ----
// Constants for the controller error reporting unit.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
package cer_pkg;

    ////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_MHZ        = 200;
    localparam int SCAN_LIMIT_MS  = 100;
    localparam int SCAN_LIMIT_CYC = SCAN_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int BLINK_HALF_MS  = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] CODE_IDX   = 12'h0fd;
    localparam logic [11:0] A_CODE     = {CODE_IDX[9:0], 2'b00};
    localparam logic [11:0] A_CTRL     = 12'h000;
    localparam logic [11:0] A_CMD      = 12'h004;
    localparam logic [11:0] A_SETUP    = 12'h008;
    localparam logic [11:0] A_ISTAT    = 12'h00c;
    localparam logic [11:0] A_IMASK    = 12'h010;
    localparam logic [11:0] A_LOGPTR   = 12'h014;
    localparam logic [11:0] A_MSG0     = 12'h018;
    localparam logic [11:0] A_LOG0     = 12'h100;
    localparam int          LOG_WORDS  = 22;
    localparam int          LOG_DEPTH  = LOG_WORDS / 2;
    localparam int          MSG_WORDS  = 4;

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_SCAN_DIS  = 0;
    localparam int CTRL_BATT_EN   = 1;
    localparam int CTRL_PROG_MODE = 2;
    localparam int CMD_CLEAR      = 0;
    localparam int CODE_BATT      = 8;
    localparam int CODE_SCAN      = 9;
    localparam int SETUP_PWR      = 0;
    localparam int SETUP_MODE     = 1;
    localparam int SETUP_RUN      = 2;
    localparam int EV_NONFATAL    = 0;
    localparam int EV_FATAL       = 1;
    localparam int EV_SETUP       = 2;
    localparam int EV_SCAN        = 3;
    localparam int EV_BATT        = 4;
    localparam int EV_MSG         = 5;
    localparam int EV_BITS        = 6;

    ////////////////////////////////////////////////////////////////////
    // Error codes and reset values
    localparam logic [7:0]  CODE_SETUP  = 8'h9b;
    localparam logic [7:0]  CODE_SCAN_V = 8'hf8;
    localparam logic [7:0]  CODE_BATT_V = 8'hf7;
    localparam logic [7:0]  CODE_NONE   = 8'h00;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [5:0]  IMASK_RST   = 6'h00;

    // Fault indicator state
    typedef enum logic [1:0] {
        CER_OK       = 2'b00,
        CER_NONFATAL = 2'b01,
        CER_FATAL    = 2'b10
    } cer_state_t;

endpackage

// ---- cer_sync.sv ----
// Two-stage synchroniser for one level from outside the pclk domain.
// Assumes the input is a slow level such as a supply monitor.
`timescale 1ns/100ps
module cer_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    ////////////////////////////////////////////////////////////////////
    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ---- cer_timer.sv ----
// Cycle counter that pulses once on reaching its limit.
// Assumes restart is a same-domain pulse; limit is at least one.
`timescale 1ns/100ps
module cer_timer #(
    parameter logic [31:0] LIMIT = 32'h0000_0010,
    parameter bit          WRAP  = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    output logic      hit
);
    logic [31:0] cnt_r;
    logic        stop_r;
    wire  logic  at_lim = (cnt_r == LIMIT - 32'h1) && !stop_r;

    ////////////////////////////////////////////////////////////////////
    // Count; a one-shot timer parks after its pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 32'h0;
            stop_r <= 1'b0;
        end else if (restart) begin
            cnt_r  <= 32'h0;
            stop_r <= 1'b0;
        end else if (at_lim) begin
            cnt_r  <= 32'h0;
            stop_r <= !WRAP;
        end else if (!stop_r) begin
            cnt_r  <= cnt_r + 32'h1;
        end
    end

    assign hit = at_lim && !restart;
endmodule

// ---- cer_unit.sv ----
// Error reporting unit: error classes, fault indicator, code byte,
// error log, setup/scan/battery checks, alarm and message handling.
// Assumes the controller core gives same-clock instruction strobes and
// a timestamp; the battery monitor is an asynchronous pin.
// Operation
// [RL1] Every detected error puts its two-digit code in bits 7:0 of the code word.
// [RL2] Every detected error is logged with its timestamp in a 22-word log.
// [RL3] The fault indicator is steady for a fatal error and flashes for a non-fatal one.
// [RL4] A fatal error is left only by reset or a clear issued in program mode.
// [RL5] A non-fatal error leaves execution running with power and run lamps lit.
// [RL6] Each detected hardware error sets its own flag bit.
// [RL7] The non-fatal alarm flashes the lamp, keeps running and stores its number.
// [RL8] A non-fatal alarm clears by alarm number 00 or by a clear command.
// [RL9] The fatal alarm halts, forces outputs off, lights the lamp and stores its number.
// [RL10] The console enters program mode before clearing a fatal alarm.
// [RL11] While its condition is on, the message instruction sends a 16-char text.
// [RL12] Bad power-on setup raises code 9b and sets setup flag bit 0.
// [RL13] Bad setup at run or monitor entry raises code 9b and sets setup flag bit 1.
// [RL14] Bad setup found during operation raises code 9b and sets setup flag bit 2.
// [RL15] A scan over 100 ms raises code f8 and sets code word bit 9 unless disabled.
// [RL16] Low battery with detection on flashes the lamp, sets bit 8 and reports f7.
// [RL17] The code byte holds the latest error while each flag stays set until cleared.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module cer_unit #(
    parameter logic [31:0] SCAN_CYC  = 32'(cer_pkg::SCAN_LIMIT_CYC),
    parameter logic [31:0] BLINK_CYC = 32'(cer_pkg::BLINK_HALF_CYC)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        nonfatal_alarm_instruction,
    input  wire logic        fatal_alarm_instruction,
    input  wire logic [7:0]  alarm_number,
    input  wire logic        message_display_instruction,
    input  wire logic        setup_bad_power_on,
    input  wire logic        setup_bad_mode_entry,
    input  wire logic        setup_bad_running,
    input  wire logic        scan_start,
    input  wire logic        battery_low_pin,
    input  wire logic [31:0] time_stamp,
    output logic             fault_indicator,
    output logic             power_indicator,
    output logic             run_indicator,
    output logic             run_enable,
    output logic             outputs_off,
    output logic             message_valid,
    output logic      [127:0] message_text,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]   ctrl_r;
    logic [7:0]   code_r;
    logic         batt_flag_r;
    logic         scan_flag_r;
    logic [2:0]   setup_r;
    logic [5:0]   istat_r;
    logic [5:0]   imask_r;
    logic [3:0]   log_ptr_r;
    logic [31:0]  log_mem [cer_pkg::LOG_WORDS];
    logic [31:0]  msg_r [cer_pkg::MSG_WORDS];
    logic         blink_r;
    logic         batt_seen_r;
    logic         msg_prev_r;
    logic [31:0]  prdata_r;
    logic         pslverr_r;
    cer_pkg::cer_state_t state_r;
    cer_pkg::cer_state_t state_nxt;
    logic         batt_low;
    logic         scan_over;
    logic         blink_tick;

    ////////////////////////////////////////////////////////////////////
    // Helpers: battery pin sync, scan watchdog, blink timebase
    cer_sync u_batt (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (battery_low_pin),
        .q       (batt_low)
    );

    cer_timer #(.LIMIT(SCAN_CYC), .WRAP(1'b0)) u_scan (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (scan_start),
        .hit     (scan_over)
    );

    cer_timer #(.LIMIT(BLINK_CYC), .WRAP(1'b1)) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (1'b0),
        .hit     (blink_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // APB decode
    wire logic setup_ph = psel && !penable;
    wire logic wr_en    = psel && penable && pwrite;
    wire logic hit_ctrl = (paddr == cer_pkg::A_CTRL);
    wire logic hit_cmd  = (paddr == cer_pkg::A_CMD);
    wire logic hit_set  = (paddr == cer_pkg::A_SETUP);
    wire logic hit_ist  = (paddr == cer_pkg::A_ISTAT);
    wire logic hit_imk  = (paddr == cer_pkg::A_IMASK);
    wire logic hit_ptr  = (paddr == cer_pkg::A_LOGPTR);
    wire logic hit_code = (paddr == cer_pkg::A_CODE);
    wire logic [11:0] msg_off = paddr - cer_pkg::A_MSG0;
    wire logic [11:0] log_off = paddr - cer_pkg::A_LOG0;
    wire logic hit_msg  = (paddr >= cer_pkg::A_MSG0) && (msg_off < 12'(4 * cer_pkg::MSG_WORDS))
                          && (paddr[1:0] == 2'b00);
    wire logic hit_log  = (paddr >= cer_pkg::A_LOG0) && (log_off < 12'(4 * cer_pkg::LOG_WORDS))
                          && (paddr[1:0] == 2'b00);
    wire logic mapped   = hit_ctrl || hit_cmd || hit_set || hit_ist || hit_imk
                          || hit_ptr || hit_code || hit_msg || hit_log;
    wire logic wr_clear = wr_en && hit_cmd && pwdata[cer_pkg::CMD_CLEAR];

    ////////////////////////////////////////////////////////////////////
    // Error detection
    wire logic prog_mode = ctrl_r[cer_pkg::CTRL_PROG_MODE];
    wire logic halted    = (state_r == cer_pkg::CER_FATAL);
    // [RL7] Alarm 01..99 raises
    wire logic nf_raise  = nonfatal_alarm_instruction && (alarm_number != cer_pkg::CODE_NONE)
                           && !halted;
    // [RL8] Alarm 00 clears
    wire logic nf_zero   = nonfatal_alarm_instruction && (alarm_number == cer_pkg::CODE_NONE);
    // [RL9] Fatal alarm strobe; number 00 is not a legal operand
    wire logic fa_raise  = fatal_alarm_instruction && (alarm_number != cer_pkg::CODE_NONE);
    // [RL15] Watchdog gated by disable
    wire logic scan_ev   = scan_over && !ctrl_r[cer_pkg::CTRL_SCAN_DIS] && !halted;
    // [RL16] Battery level only when enabled
    wire logic batt_now  = batt_low && ctrl_r[cer_pkg::CTRL_BATT_EN];
    wire logic batt_ev   = batt_now && !batt_seen_r;
    wire logic [2:0] set_ev = {setup_bad_running, setup_bad_mode_entry, setup_bad_power_on};
    wire logic setup_ev  = |set_ev;
    wire logic any_ev    = fa_raise || nf_raise || setup_ev || scan_ev || batt_ev;
    // Fatal clear needs program mode; anything else clears freely
    wire logic clr_fatal = wr_clear && prog_mode;
    wire logic clr_nf    = wr_clear || nf_zero;
    wire logic msg_rise  = message_display_instruction && !msg_prev_r;

    ////////////////////////////////////////////////////////////////////
    // [RL17] Latest code wins; fatal ranks first in one cycle
    wire logic [7:0] new_code = fa_raise ? alarm_number :
                                nf_raise ? alarm_number :
                                setup_ev ? cer_pkg::CODE_SETUP :
                                scan_ev  ? cer_pkg::CODE_SCAN_V :
                                           cer_pkg::CODE_BATT_V;

    ////////////////////////////////////////////////////////////////////
    // Error class; only reset or a program-mode clear leaves fatal
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cer_pkg::CER_OK: begin
                if (fa_raise) state_nxt = cer_pkg::CER_FATAL;
                else if (any_ev) state_nxt = cer_pkg::CER_NONFATAL;
            end
            cer_pkg::CER_NONFATAL: begin
                if (fa_raise) state_nxt = cer_pkg::CER_FATAL;
                else if (any_ev) state_nxt = cer_pkg::CER_NONFATAL;
                else if (clr_nf) state_nxt = cer_pkg::CER_OK;
            end
            // [RL4] Program-mode clear exits fatal
            cer_pkg::CER_FATAL: begin
                if (fa_raise) state_nxt = cer_pkg::CER_FATAL;
                else if (clr_fatal) state_nxt = cer_pkg::CER_OK;
            end
            default: state_nxt = cer_pkg::CER_OK;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_r <= cer_pkg::CER_OK;
        else          state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Code byte and error flags; a new error beats a same-cycle clear
    wire logic clr_code = halted ? clr_fatal : clr_nf;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r      <= cer_pkg::CODE_NONE;
            batt_flag_r <= 1'b0;
            scan_flag_r <= 1'b0;
            setup_r     <= 3'h0;
            batt_seen_r <= 1'b0;
        // [RL1] Code into low byte
        end else begin
            if (any_ev)        code_r <= new_code;
            else if (clr_code) code_r <= cer_pkg::CODE_NONE;
            // [RL6] Per-error flag bits
            if (batt_ev)       batt_flag_r <= 1'b1;
            else if (clr_code) batt_flag_r <= 1'b0;
            if (scan_ev)       scan_flag_r <= 1'b1;
            else if (clr_code) scan_flag_r <= 1'b0;
            // [RL12] [RL13] [RL14] Setup flag bits
            setup_r     <= set_ev | (clr_code ? 3'h0 : setup_r);
            batt_seen_r <= batt_now;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // [RL2] Log code and time, wrapping over 11 entries
    wire logic [4:0] log_wa = {log_ptr_r, 1'b0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_ptr_r <= 4'h0;
        end else if (any_ev) begin
            log_ptr_r <= (log_ptr_r == 4'(cer_pkg::LOG_DEPTH - 1)) ? 4'h0 : log_ptr_r + 4'h1;
        end
    end

    // Log storage has no reset; the pointer says which entries are valid
    always_ff @(posedge pclk) begin
        if (any_ev) begin
            log_mem[log_wa]        <= {24'h0, new_code};
            log_mem[log_wa + 5'h1] <= time_stamp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= cer_pkg::CTRL_RST;
            imask_r <= cer_pkg::IMASK_RST;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_r  <= pwdata[2:0];
            if (hit_imk)  imask_r <= pwdata[5:0];
        end
    end

    // Message text; word 0 holds the first four characters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < cer_pkg::MSG_WORDS; i++) msg_r[i] <= 32'h0;
        end else if (wr_en && hit_msg) begin
            msg_r[msg_off[3:2]] <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, write one to clear, set wins
    wire logic [5:0] ev_vec = {msg_rise, batt_ev, scan_ev, setup_ev, fa_raise, nf_raise};
    wire logic [5:0] w1c    = (wr_en && hit_ist) ? pwdata[5:0] : 6'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r    <= 6'h00;
            msg_prev_r <= 1'b0;
        end else begin
            istat_r    <= ev_vec | (istat_r & ~w1c);
            msg_prev_r <= message_display_instruction;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux, sampled in the setup phase for a zero-wait answer
    wire logic [31:0] rd_val =
        hit_ctrl ? {29'h0, ctrl_r} :
        hit_set  ? {29'h0, setup_r} :
        hit_ist  ? {26'h0, istat_r} :
        hit_imk  ? {26'h0, imask_r} :
        hit_ptr  ? {28'h0, log_ptr_r} :
        hit_code ? {22'h0, scan_flag_r, batt_flag_r, code_r} :
        hit_msg  ? msg_r[msg_off[3:2]] :
        hit_log  ? log_mem[log_off[6:2]] :
                   32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? 32'h0 : rd_val;
            pslverr_r <= !mapped;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = pslverr_r && psel && penable;

    ////////////////////////////////////////////////////////////////////
    // Indicator blink timebase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)        blink_r <= 1'b0;
        else if (blink_tick) blink_r <= !blink_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Indicators and run control
    // [RL3] Steady for fatal, flashing for non-fatal
    assign fault_indicator = halted || ((state_r == cer_pkg::CER_NONFATAL) && blink_r);
    // [RL5] Power lamp and run stay on through non-fatal errors
    assign power_indicator = 1'b1;
    assign run_indicator   = !halted && !prog_mode;
    // [RL9] Halt and force outputs off
    assign run_enable      = !halted;
    assign outputs_off     = halted;
    assign irq             = |(istat_r & imask_r);

    ////////////////////////////////////////////////////////////////////
    // [RL11] Message text offered while the condition holds and the unit is not halted
    assign message_valid = message_display_instruction && !halted;
    assign message_text  = {msg_r[0], msg_r[1], msg_r[2], msg_r[3]};

endmodule

// ---- cer_unit_props.sv ----
// Port checks for the error unit.
// Assumes a bind onto cer_unit.
`timescale 1ns/100ps
module cer_unit_props #(
    parameter logic [31:0] SCAN_CYC  = 32'd50,
    parameter logic [31:0] BLINK_CYC = 32'd4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nonfatal_alarm_instruction,
    input wire logic        fatal_alarm_instruction,
    input wire logic [7:0]  alarm_number,
    input wire logic        message_display_instruction,
    input wire logic        fault_indicator,
    input wire logic        power_indicator,
    input wire logic        run_indicator,
    input wire logic        run_enable,
    input wire logic        outputs_off,
    input wire logic        message_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////
    // Decoded causes
    wire clr_w = psel && penable && pwrite && paddr == cer_pkg::A_CMD;
    wire fal_w = fatal_alarm_instruction && alarm_number != 8'h00;
    wire nfa_w = nonfatal_alarm_instruction && alarm_number != 8'h00;
    logic [31:0] lit_r;

    // Steady-on run length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lit_r <= 32'h0;
        else lit_r <= (run_enable && fault_indicator) ? lit_r + 32'h1 : 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    a_fatal_stops: assert property (fal_w |=> outputs_off && !run_enable)
        else $error("no stop");
    a_no_false_fatal: assert property (!outputs_off && !fal_w |=> !outputs_off)
        else $error("false stop");
    a_fatal_sticky: assert property (outputs_off && !clr_w |=> outputs_off)
        else $error("stop left");
    a_lamp_steady: assert property (outputs_off |-> fault_indicator && !run_indicator)
        else $error("lamp not lit");
    a_flash_bound: assert property (lit_r <= BLINK_CYC) else $error("no flash");
    a_nonfatal_runs: assert property (nfa_w && !outputs_off && !fal_w
        |=> run_enable && power_indicator)
        else $error("halted");
    a_msg_follows: assert property (message_valid == (message_display_instruction
        && !outputs_off))
        else $error("msg wrong");
    a_bad_addr: assert property (psel && penable && paddr == 12'hffc |-> pslverr)
        else $error("no error");
    a_zero_wait: assert property (psel && penable |-> pready) else $error("stalled");

    c_fatal: cover property (fal_w);
    c_nonfatal: cover property (nfa_w);
    c_fatal_clear: cover property (clr_w && outputs_off);
endmodule

bind cer_unit cer_unit_props #(.SCAN_CYC(SCAN_CYC), .BLINK_CYC(BLINK_CYC)) i_cer_unit_props (.*);

// ---- cer_console.sv ----
// Console model: APB master.
// Assumes callers enter just after a pclk edge.
`timescale 1ns/100ps
module cer_console (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    // Idle bus from time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // One transfer, held until pready; bounded
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit to);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        to = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic clear_fatal(output bit to);
        logic [31:0] q;
        bit t1;
        xfer(1'b1, cer_pkg::A_CTRL, 32'h1 << cer_pkg::CTRL_PROG_MODE, q, t1);
        xfer(1'b1, cer_pkg::A_CMD, 32'h1, q, to);
        to |= t1;
    endtask
endmodule

// ---- test_cer_unit.sv ----
// Bench for the error unit.
// Assumes short scan and blink counts.
`timescale 1ns/100ps
module test_cer_unit;
    localparam logic [31:0] BLINK = 32'd4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [4:0]  ev_r = 5'h0;
    logic [7:0]  num_r = 8'h0;
    logic        msg_r = 1'b0;
    logic        scan_r = 1'b0;
    logic        batt_r = 1'b0;
    logic [31:0] ts_r = 32'h0;
    logic [31:0] lts;
    logic        psel, penable, pwrite, pready, pslverr, fault_indicator, power_indicator;
    logic        run_indicator, run_enable, outputs_off, message_valid, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [127:0] message_text;
    logic [32:0] exp_q[$];
    int          mismatches = 0;
    int          n_tests = 0;

    ////////////////////////////////////////////////////////////////
    // Clock, time stamp
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) ts_r <= ts_r + 32'h1;

    cer_unit #(.SCAN_CYC(32'd50), .BLINK_CYC(BLINK)) i_cer_unit (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .nonfatal_alarm_instruction(ev_r[0]), .fatal_alarm_instruction(ev_r[1]),
        .alarm_number(num_r), .message_display_instruction(msg_r),
        .setup_bad_power_on(ev_r[2]), .setup_bad_mode_entry(ev_r[3]),
        .setup_bad_running(ev_r[4]), .scan_start(scan_r), .battery_low_pin(batt_r),
        .time_stamp(ts_r), .fault_indicator, .power_indicator, .run_indicator,
        .run_enable, .outputs_off, .message_valid, .message_text, .irq);

    cer_console i_cer_console (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready);

    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t %h %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        chk({32'h0, got}, {32'h0, exp});
    endtask

    task automatic hang(input bit to);
        if (to) begin
            mismatches++;
            test_done();
        end
    endtask

    // Reads note {pslverr, prdata}
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e = 33'h0);
        logic [31:0] q;
        bit to;
        if (!w)
            exp_q.push_back(e);
        i_cer_console.xfer(w, a, d, q, to);
        hang(to);
    endtask

    // One-cycle event; lts is its stamp
    task automatic ev(input int k, input logic [7:0] n);
        @(posedge pclk);
        ev_r  <= 5'h1 << k;
        num_r <= n;
        @(posedge pclk);
        ev_r <= 5'h0;
        lts = ts_r;
        @(posedge pclk);
    endtask

    // Reads against oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  n;
        logic [31:0] r;
        bit          hi, lo, to;
        void'($urandom(32'h3e6198cf));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, cer_pkg::A_CTRL, 0);
        bus(0, cer_pkg::A_IMASK, 0);
        bus(0, cer_pkg::A_CODE, 0);
        bus(0, 12'hffc, 0, 33'h100000000);
        r = $urandom;
        bus(1, cer_pkg::A_CTRL, r);
        bus(0, cer_pkg::A_CTRL, 0, {30'h0, r[2:0]});
        // Watchdog runs from reset: keep it off until its scenario
        bus(1, cer_pkg::A_CTRL, 32'h1);
        bus(1, cer_pkg::A_MSG0, r);
        msg_r <= 1'b1;
        bus(0, cer_pkg::A_MSG0, 0, {1'b0, r});
        chk_pin(message_valid, 1'b1);
        chk({1'b0, message_text[127:96]}, {1'b0, r});
        // Random non-fatal alarm
        bus(1, cer_pkg::A_IMASK, 32'h1);
        n = {4'($urandom % 10), 4'($urandom % 9 + 1)};
        ev(0, n);
        chk_pin(run_enable, 1'b1);
        chk_pin(irq, 1'b1);
        bus(0, cer_pkg::A_CODE, 0, {25'h0, n});
        bus(0, cer_pkg::A_LOG0, 0, {25'h0, n});
        bus(0, cer_pkg::A_LOG0 + 12'h4, 0, {1'b0, lts});
        {hi, lo} = 2'b00;
        repeat (2 * BLINK + 1) begin
            @(posedge pclk);
            hi |= (fault_indicator === 1'b1);
            lo |= (fault_indicator === 1'b0);
        end
        chk_pin(hi & lo, 1'b1);
        bus(1, cer_pkg::A_ISTAT, 32'h1);
        @(posedge pclk);
        chk_pin(irq, 1'b0);
        // Both ways out of a non-fatal alarm
        ev(0, 8'h00);
        bus(0, cer_pkg::A_CODE, 0);
        ev(0, 8'h99);
        bus(1, cer_pkg::A_CMD, 32'h1);
        bus(0, cer_pkg::A_CODE, 0);
        // Setup flags pile up
        for (int k = 0; k < 3; k++) begin
            ev(k + 2, 8'h00);
            bus(0, cer_pkg::A_SETUP, 0, 33'((1 << (k + 1)) - 1));
            bus(0, cer_pkg::A_CODE, 0, 33'h9b);
        end
        for (int k = 0; k < 2; k++) begin
            bus(1, cer_pkg::A_CTRL, 32'(k));
            scan_r <= 1'b1;
            @(posedge pclk);
            scan_r <= 1'b0;
            repeat (60) @(posedge pclk);
            bus(0, cer_pkg::A_CODE, 0, k ? 33'h0 : 33'h2f8);
            bus(0, cer_pkg::A_SETUP, 0, k ? 33'h0 : 33'h7);
            bus(1, cer_pkg::A_CMD, 32'h1);
        end
        bus(1, cer_pkg::A_CTRL, 32'h2);
        batt_r <= 1'b1;
        repeat (6) @(posedge pclk);
        bus(0, cer_pkg::A_CODE, 0, 33'h1f7);
        batt_r <= 1'b0;
        bus(1, cer_pkg::A_CMD, 32'h1);
        bus(1, cer_pkg::A_CTRL, 32'h0);
        // Fatal alarm and its clears
        ev(1, 8'h00);
        chk_pin(outputs_off, 1'b0);
        ev(1, 8'h45);
        chk_pin(outputs_off, 1'b1);
        chk_pin(run_enable, 1'b0);
        chk_pin(fault_indicator, 1'b1);
        chk_pin(message_valid, 1'b0);
        ev(0, 8'h12);
        bus(0, cer_pkg::A_CODE, 0, 33'h45);
        bus(1, cer_pkg::A_CMD, 32'h1);
        @(posedge pclk);
        chk_pin(outputs_off, 1'b1);
        i_cer_console.clear_fatal(to);
        hang(to);
        @(posedge pclk);
        chk_pin(outputs_off, 1'b0);
        bus(0, cer_pkg::A_CODE, 0);
        test_done();
    end
endmodule
